// ==== src/sp_float_unit_consts.vh ====
`ifndef SP_FLOAT_UNIT_CONSTS_VH
`define SP_FLOAT_UNIT_CONSTS_VH
// Register byte offsets
`define OFS_SRC_A   8'h00
`define OFS_SRC_B   8'h04
`define OFS_SRC_D   8'h08
`define OFS_CTRL    8'h0c
`define OFS_CMD     8'h10
`define OFS_STATUS  8'h14
`define OFS_RESULT  8'h18
// Control fields
`define CTRL_RMODE_LO 0
`define CTRL_INV_EN   2
`define CTRL_DBZ_EN   3
`define CTRL_OVF_EN   4
`define CTRL_UNF_EN   5
`define CTRL_INX_EN   6
`define CTRL_RST      7'h00
// Status fields
`define ST_INV   0
`define ST_DBZ   1
`define ST_OVF   2
`define ST_UNF   3
`define ST_INX   4
`define ST_LG    5
`define ST_LS    6
`define ST_HG    7
`define ST_HS    8
`define ST_EXC   9
`define ST_RND   10
// Rounding modes
`define RM_NEAR  2'h0
`define RM_ZERO  2'h1
`define RM_POS   2'h2
`define RM_NEG   2'h3
// Operation codes
`define OP_CTSIZ 3'h0
`define OP_CTUF  3'h1
`define OP_CTUI  3'h2
`define OP_CTUIZ 3'h3
`define OP_DIV   3'h4
`define OP_MADD  3'h5
`define OP_MAX   3'h6
// Saturation values
`define POS_MAX  32'h7f7f_ffff
`define NEG_MAX  32'hff7f_ffff
`define SI_MAX   32'h7fff_ffff
`define SI_MIN   32'h8000_0000
`define UI_MAX   32'hffff_ffff
`endif

// ==== src/sp_float_unit.v ====
`include "sp_float_unit_consts.vh"

// Overview of operation
// - Signed integer conversion truncates toward zero, saturating outside 32-bit signed range
// - Unsigned fraction conversion uses current rounding mode, saturates when out of range
// - Unsigned integer conversion uses current rounding mode, saturates when out of range
// - Truncating unsigned integer conversion always rounds toward zero and saturates
// - Conversions treat a NaN source as zero
// - Conversion of inf, denormal, NaN or overflow sets invalid, clears guard bits
// - Enabled invalid requests exception, suppresses write; signed truncation sets nothing more
// - An inexact conversion sets the inexact sticky flag
// - Enabled inexact raises round exception, writes truncated value and low guard bits
// - Divide writes first over second; NaN or infinite divisor gives signed zero
// - Divide gives signed maximum for zero or denormal divisor, NaN or infinite dividend, overflow, underflow
// - Divide flags invalid on inf, denormal, NaN operand or zero over zero
// - Zero divisor with normal dividend sets divide-by-zero, excepts when enabled
// - Arithmetic sets overflow and underflow; enabled ones except and keep destination
// - Inexact or unenabled overflow sets inexact sticky when no exception is taken
// - Divide clears guard bits on overflow, underflow, divide-by-zero or invalid
// - Multiply-add adds product to destination; zero or denormal factor gives zero
// - NaN or infinite factor makes signed maximum, written directly as result
// - NaN or infinite addend gives maximum signed by addend; overflow gives maximum
// - Multiply-add underflow writes minus zero under round-down, else plus zero
// - Maximum writes second source when first is smaller, else first source
// - With exactly one NaN operand maximum selects the other operand
// - Maximum flags invalid on inf, denormal or NaN; enabled invalid suppresses write
module sp_float_unit (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         exc_req,
    output reg         exc_round,
    output reg         wb_en,
    output reg  [31:0] wb_data
);
    // Class code: {nan_or_inf, denormal, zero}
    function [2:0] fclass;
        input [31:0] x;
        begin
            fclass = {&x[30:23], ~|x[30:23] & |x[22:0], ~|x[30:0]};
        end
    endfunction
    function rnd_up;
        input [1:0] m;
        input       s;
        input       lsb;
        input       g;
        input       st;
        begin
            case (m)
                `RM_NEAR: rnd_up = g & (st | lsb);
                `RM_POS:  rnd_up = ~s & (g | st);
                `RM_NEG:  rnd_up = s & (g | st);
                default:  rnd_up = 1'b0;
            endcase
        end
    endfunction
    function [6:0] lzc76;
        input [75:0] v;
        integer      i;
        reg          found;
        begin
            lzc76 = 7'd76;
            found = 1'b0;
            for (i = 75; i >= 0; i = i - 1) begin
                if (!found && v[i]) begin
                    lzc76 = 7'd75 - i[6:0];
                    found = 1'b1;
                end
            end
        end
    endfunction
    reg  [31:0] src_a_q, src_b_q, src_d_q;
    reg  [6:0]  ctrl_q;
    reg  [2:0]  op_q;
    reg  [10:0] status_q;
    reg  [31:0] rd_d;
    reg         hit_d;
    wire [1:0] rmode  = ctrl_q[`CTRL_RMODE_LO+1:`CTRL_RMODE_LO];
    wire       access = psel & penable & pready;
    wire       issue  = access & pwrite & (paddr == `OFS_CMD);
    wire [2:0] op     = pwdata[2:0];
    wire [2:0] ca     = fclass(src_a_q);
    wire [2:0] cb     = fclass(src_b_q);
    wire [2:0] cd     = fclass(src_d_q);
    wire       a_nan  = ca[2] & |src_a_q[22:0];
    wire       b_nan  = cb[2] & |src_b_q[22:0];
    wire       a_bad  = ca[2] | ca[1];
    wire       b_bad  = cb[2] | cb[1];
    wire [23:0] ma    = {1'b1, src_a_q[22:0]};
    wire [23:0] mb    = {1'b1, src_b_q[22:0]};
    wire [23:0] md    = {1'b1, src_d_q[22:0]};
    // Conversions
    reg signed [10:0] cv_sh;
    reg [127:0] cv_w;
    reg [32:0]  cv_mr;
    reg [31:0]  cv_res, cv_tr;
    reg [1:0]   cv_mode;
    reg         cv_big, cv_tiny, cv_g, cv_s, cv_ovf, cv_inv, cv_sgn;
    always @* begin
        cv_sgn  = src_b_q[31];
        cv_sh   = $signed({3'b000, src_b_q[30:23]}) - 11'sd86
                  + ((op == `OP_CTUF) ? 11'sd32 : 11'sd0);
        cv_tiny = cv_sh < 0;
        cv_big  = cv_sh > 11'sd103;
        cv_w    = (cv_tiny | cv_big) ? 128'd0 : ({104'd0, mb} << cv_sh[6:0]);
        cv_g    = cv_w[63];
        cv_s    = |cv_w[62:0] | cv_tiny;
        cv_mode = (op == `OP_CTSIZ || op == `OP_CTUIZ) ? `RM_ZERO : rmode;
        cv_mr   = {1'b0, cv_w[95:64]} + {32'd0, rnd_up(cv_mode, cv_sgn, cv_w[64], cv_g, cv_s)};
        if (op == `OP_CTSIZ) begin
            cv_ovf = cv_big | |cv_w[127:96] | (~cv_sgn & cv_mr > 33'h0_7fff_ffff)
                     | (cv_sgn & cv_mr > 33'h0_8000_0000);
            cv_res = cv_ovf ? (cv_sgn ? `SI_MIN : `SI_MAX)
                            : (cv_sgn ? 32'd0 - cv_mr[31:0] : cv_mr[31:0]);
            cv_tr  = cv_sgn ? 32'd0 - cv_w[95:64] : cv_w[95:64];
        end else begin
            // Negative values below one may round to zero; anything else saturates
            cv_ovf = cv_big | |cv_w[127:96] | cv_mr[32] | (cv_sgn & |cv_mr);
            cv_res = cv_ovf ? (cv_sgn ? 32'd0 : `UI_MAX) : cv_mr[31:0];
            cv_tr  = cv_sgn ? 32'd0 : cv_w[95:64];
        end
        if (b_nan | cb[1] | cb[0]) begin
            cv_res = 32'd0;
            cv_tr  = 32'd0;
            cv_ovf = 1'b0;
        end else if (cb[2]) begin
            cv_res = (op == `OP_CTSIZ) ? (cv_sgn ? `SI_MIN : `SI_MAX)
                                       : (cv_sgn ? 32'd0 : `UI_MAX);
            cv_ovf = 1'b0;
        end
        cv_inv = b_bad | cv_ovf;
        if (cv_inv | cb[0]) begin
            cv_g = 1'b0;
            cv_s = 1'b0;
        end
    end
    // Divide
    reg [48:0] dv_q, dv_r;
    reg signed [10:0] dv_e;
    reg [23:0] dv_m;
    reg        dv_g, dv_s, dv_sgn;
    always @* begin
        dv_sgn = src_a_q[31] ^ src_b_q[31];
        dv_q   = {ma, 25'd0} / {25'd0, mb};
        dv_r   = {ma, 25'd0} % {25'd0, mb};
        dv_e   = $signed({3'b000, src_a_q[30:23]}) - $signed({3'b000, src_b_q[30:23]})
                 + 11'sd127;
        if (dv_q[25]) begin
            dv_m = dv_q[25:2];
            dv_g = dv_q[1];
            dv_s = dv_q[0] | |dv_r;
        end else begin
            dv_m = dv_q[24:1];
            dv_g = dv_q[0];
            dv_s = |dv_r;
            dv_e = dv_e - 11'sd1;
        end
    end
    // Multiply-add: product and addend aligned in a 76-bit field, bit 72 is one
    reg [47:0] ml_p;
    reg [75:0] ml_x, ml_y, ml_big, ml_sum, ml_n;
    reg [151:0] ml_sh;
    reg signed [10:0] ml_ep, ml_ed, ml_ex, ml_df, ml_e;
    reg [6:0]  ml_amt, ml_lz;
    reg        ml_ps, ml_bs, ml_ss, ml_sgn, ml_st, ml_pz, ml_dz;
    always @* begin
        ml_ps  = src_a_q[31] ^ src_b_q[31];
        ml_pz  = ca[0] | ca[1] | cb[0] | cb[1];
        ml_dz  = cd[0] | cd[1];
        ml_p   = ma * mb;
        ml_x   = ml_pz ? 76'd0 : {2'b00, ml_p, 26'd0};
        ml_y   = ml_dz ? 76'd0 : {3'b000, md, 49'd0};
        // A zero operand takes a tiny exponent so it never leads the alignment
        ml_ep  = ml_pz ? -11'sd500 : $signed({3'b000, src_a_q[30:23]})
                 + $signed({3'b000, src_b_q[30:23]}) - 11'sd127;
        ml_ed  = ml_dz ? -11'sd500 : $signed({3'b000, src_d_q[30:23]});
        ml_df  = (ml_ep >= ml_ed) ? ml_ep - ml_ed : ml_ed - ml_ep;
        ml_amt = (ml_df > 11'sd127) ? 7'd127 : ml_df[6:0];
        if (ml_ep >= ml_ed) begin
            ml_big = ml_x;
            ml_bs  = ml_ps;
            ml_ss  = src_d_q[31];
            ml_ex  = ml_ep;
            ml_sh  = {ml_y, 76'd0} >> ml_amt;
        end else begin
            ml_big = ml_y;
            ml_bs  = src_d_q[31];
            ml_ss  = ml_ps;
            ml_ex  = ml_ed;
            ml_sh  = {ml_x, 76'd0} >> ml_amt;
        end
        ml_st = |ml_sh[75:0];
        if (ml_bs == ml_ss) begin
            ml_sum = ml_big + ml_sh[151:76];
            ml_sgn = ml_bs;
        end else if (ml_big >= ml_sh[151:76]) begin
            ml_sum = ml_big - ml_sh[151:76];
            ml_sgn = ml_bs;
        end else begin
            ml_sum = ml_sh[151:76] - ml_big;
            ml_sgn = ml_ss;
        end
        ml_lz = lzc76(ml_sum);
        ml_n  = ml_sum << ml_lz;
        ml_e  = ml_ex + 11'sd3 - $signed({4'b0000, ml_lz});
    end
    // Shared rounding and packing
    reg [23:0] n_m;
    reg signed [10:0] n_e, r_e;
    reg [24:0] r_m;
    reg        n_s, n_g, n_st, r_ovf, r_unf;
    reg [31:0] r_pack, t_pack;
    always @* begin
        if (op == `OP_DIV) begin
            n_s  = dv_sgn;
            n_e  = dv_e;
            n_m  = dv_m;
            n_g  = dv_g;
            n_st = dv_s;
        end else begin
            n_s  = ml_sgn;
            n_e  = ml_e;
            n_m  = ml_n[75:52];
            n_g  = ml_n[51];
            n_st = |ml_n[50:0] | ml_st;
        end
        r_m = {1'b0, n_m} + {24'd0, rnd_up(rmode, n_s, n_m[0], n_g, n_st)};
        r_e = r_m[24] ? n_e + 11'sd1 : n_e;
        r_ovf  = r_e > 11'sd254;
        r_unf  = r_e < 11'sd1;
        r_pack = {n_s, r_e[7:0], r_m[24] ? r_m[23:1] : r_m[22:0]};
        t_pack = {n_s, n_e[7:0], n_m[22:0]};
    end
    // Per-operation outcome
    reg [31:0] o_res, o_tr;
    reg        o_inv, o_dbz, o_ovf, o_unf, o_inx, o_g, o_s, o_clr;
    reg        x_data, x_inx, x_rnd;
    reg        mx_lt;
    reg [31:0] mx_sel;
    always @* begin
        o_res = 32'd0;
        o_tr  = 32'd0;
        o_inv = 1'b0;
        o_dbz = 1'b0;
        o_ovf = 1'b0;
        o_unf = 1'b0;
        o_inx = 1'b0;
        o_g   = 1'b0;
        o_s   = 1'b0;
        mx_lt = 1'b0;
        mx_sel = src_a_q;
        case (op)
            `OP_CTSIZ, `OP_CTUF, `OP_CTUI, `OP_CTUIZ, 3'h7: begin
                o_res = cv_res;
                o_tr  = cv_tr;
                o_inv = cv_inv;
                o_inx = ~cv_inv & ~cb[0] & (cv_g | cv_s);
                o_g   = cv_g;
                o_s   = cv_s;
            end
            `OP_DIV: begin
                o_inv = a_bad | b_bad | (ca[0] & cb[0]);
                o_dbz = cb[0] & ~ca[0] & ~a_bad;
                if (cb[2])
                    o_res = {dv_sgn, 31'd0};
                else if (cb[0] | cb[1] | ca[2])
                    o_res = dv_sgn ? `NEG_MAX : `POS_MAX;
                else if (ca[0] | ca[1])
                    o_res = {dv_sgn, 31'd0};
                else begin
                    o_ovf = r_ovf;
                    o_unf = r_unf;
                    o_res = (r_ovf | r_unf) ? (dv_sgn ? `NEG_MAX : `POS_MAX) : r_pack;
                    o_inx = n_g | n_st;
                    o_g   = n_g;
                    o_s   = n_st;
                end
                o_tr = (o_ovf | o_unf | o_inx) ? t_pack : o_res;
            end
            `OP_MADD: begin
                o_inv = a_bad | b_bad;
                if (ca[2] | cb[2])
                    o_res = ml_ps ? `NEG_MAX : `POS_MAX;
                else if (cd[2])
                    o_res = src_d_q[31] ? `NEG_MAX : `POS_MAX;
                else if (ml_sum == 76'd0 && !ml_st)
                    o_res = {(ml_pz & ml_dz) ? ((rmode == `RM_NEG) ? ml_ps | src_d_q[31]
                            : ml_ps & src_d_q[31]) : (rmode == `RM_NEG), 31'd0};
                else begin
                    o_ovf = r_ovf;
                    o_unf = r_unf;
                    o_inx = n_g | n_st;
                    o_g   = n_g;
                    o_s   = n_st;
                    if (r_ovf)
                        o_res = n_s ? `NEG_MAX : `POS_MAX;
                    else if (r_unf)
                        o_res = {(rmode == `RM_NEG), 31'd0};
                    else
                        o_res = r_pack;
                end
                o_tr = (o_inx & ~o_ovf & ~o_unf) ? t_pack : o_res;
            end
            default: begin
                o_inv = a_bad | b_bad;
                if (src_a_q[31] != src_b_q[31])
                    mx_lt = src_a_q[31];
                else if (src_a_q[31])
                    mx_lt = src_a_q[30:0] > src_b_q[30:0];
                else
                    mx_lt = src_a_q[30:0] < src_b_q[30:0];
                mx_sel = mx_lt ? src_b_q : src_a_q;
                if (a_nan & ~b_nan)
                    mx_sel = src_b_q;
                else if (b_nan & ~a_nan)
                    mx_sel = src_a_q;
                if (fclass(mx_sel) == 3'b010)
                    o_res = {mx_sel[31], 31'd0};
                else if (fclass(mx_sel) == 3'b100)
                    o_res = mx_sel[31] ? `NEG_MAX : `POS_MAX;
                else
                    o_res = mx_sel;
                o_tr = o_res;
            end
        endcase
        o_clr  = o_inv | o_dbz | o_ovf | o_unf;
        x_data = (o_inv & ctrl_q[`CTRL_INV_EN])
               | (~o_inv & o_dbz & ctrl_q[`CTRL_DBZ_EN])
               | (~o_inv & ~o_dbz & ((o_ovf & ctrl_q[`CTRL_OVF_EN])
                                    | (o_unf & ctrl_q[`CTRL_UNF_EN])));
        x_inx  = ~x_data & ~o_inv & ~o_dbz
               & (o_inx | (o_ovf & ~ctrl_q[`CTRL_OVF_EN]));
        x_rnd  = x_inx & ctrl_q[`CTRL_INX_EN];
    end
    always @* begin
        hit_d = 1'b1;
        case (paddr)
            `OFS_SRC_A:  rd_d = src_a_q;
            `OFS_SRC_B:  rd_d = src_b_q;
            `OFS_SRC_D:  rd_d = src_d_q;
            `OFS_CTRL:   rd_d = {25'd0, ctrl_q};
            `OFS_CMD:    rd_d = {29'd0, op_q};
            `OFS_STATUS: rd_d = {21'd0, status_q};
            `OFS_RESULT: rd_d = wb_data;
            default: begin
                rd_d  = 32'd0;
                hit_d = 1'b0;
            end
        endcase
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_a_q   <= 32'd0;
            src_b_q   <= 32'd0;
            src_d_q   <= 32'd0;
            ctrl_q    <= `CTRL_RST;
            op_q      <= 3'd0;
            status_q  <= 11'd0;
            prdata    <= 32'd0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            exc_req   <= 1'b0;
            exc_round <= 1'b0;
            wb_en     <= 1'b0;
            wb_data   <= 32'd0;
        end else begin
            // Zero wait states: ready rises in every access phase
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_d;
            if (psel & ~penable)
                prdata <= rd_d;
            exc_req <= 1'b0;
            wb_en   <= 1'b0;
            if (access & pwrite) begin
                case (paddr)
                    `OFS_SRC_A: src_a_q <= pwdata;
                    `OFS_SRC_B: src_b_q <= pwdata;
                    `OFS_SRC_D: src_d_q <= pwdata;
                    `OFS_CTRL:  ctrl_q  <= pwdata[6:0];
                    `OFS_STATUS: status_q[`ST_INX] <= status_q[`ST_INX] & ~pwdata[`ST_INX];
                    default: ;
                endcase
            end
            if (issue) begin
                op_q      <= op;
                exc_req   <= x_data | x_rnd;
                exc_round <= x_rnd & ~x_data;
                wb_en     <= ~x_data;
                if (!x_data) begin
                    wb_data <= x_rnd ? o_tr : o_res;
                    src_d_q <= x_rnd ? o_tr : o_res;
                end
                status_q[`ST_INV] <= o_inv;
                // Signed truncation with a taken invalid exception leaves the rest alone
                if (!(op == `OP_CTSIZ && x_data)) begin
                    status_q[`ST_DBZ] <= o_dbz;
                    status_q[`ST_OVF] <= o_ovf & ~o_inv;
                    status_q[`ST_UNF] <= o_unf & ~o_inv;
                    status_q[`ST_LG]  <= ~o_clr & o_g;
                    status_q[`ST_LS]  <= ~o_clr & o_s;
                end
                status_q[`ST_HG]  <= 1'b0;
                status_q[`ST_HS]  <= 1'b0;
                status_q[`ST_INX] <= status_q[`ST_INX] | x_inx;
                status_q[`ST_EXC] <= x_data | x_rnd;
                status_q[`ST_RND] <= x_rnd & ~x_data;
            end
        end
    end
endmodule

// ==== bench/sp_float_unit_monitor.sv ====
`include "sp_float_unit_consts.vh"
module sp_float_unit_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        exc_req,
    input wire logic        exc_round,
    input wire logic        wb_en,
    input wire logic [31:0] wb_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic cmd_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Command accepted last edge; every outcome must trace back to one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cmd_q <= 1'b0;
        else cmd_q <= psel && penable && pready && pwrite && paddr == `OFS_CMD;
    end
    ready_access_a: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    unmapped_err_a: assert property (psel && penable && paddr > 8'h1b |-> pslverr)
        else $error("no error on unmapped address");
    mapped_ok_a: assert property (psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'b00
        |-> !pslverr) else $error("error on mapped address");
    pulse_cause_a: assert property ((wb_en || exc_req) == cmd_q)
        else $error("outcome pulse not tied to one command");
    data_exc_nowb_a: assert property (exc_req && !exc_round |-> !wb_en)
        else $error("write not suppressed on data exception");
    round_exc_wb_a: assert property (exc_req && exc_round |-> wb_en)
        else $error("round exception without writeback");
    one_pulse_a: assert property (exc_req |=> !exc_req)
        else $error("exception request longer than one cycle");
    wb_hold_a: assert property (!wb_en |-> $stable(wb_data))
        else $error("result changed without writeback");
    result_read_a: assert property (psel && penable && !pwrite && paddr == `OFS_RESULT
        |-> prdata == wb_data) else $error("result register differs");
endmodule
bind sp_float_unit sp_float_unit_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .exc_req(exc_req), .exc_round(exc_round),
    .wb_en(wb_en), .wb_data(wb_data));

// ==== bench/pipe_model.sv ====
module pipe_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        exc_req,
    input  wire logic        exc_round,
    input  wire logic        wb_en,
    input  wire logic [31:0] wb_data,
    output logic      [31:0] dest_q,
    output int               wb_cnt,
    output int               exc_cnt,
    output int               rnd_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    // Destination only moves on a writeback, as the core's register file would
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dest_q <= 32'h0;
            wb_cnt <= 0;
            exc_cnt <= 0;
            rnd_cnt <= 0;
        end else begin
            if (wb_en) begin
                dest_q <= wb_data;
                wb_cnt <= wb_cnt + 1;
            end
            if (exc_req) exc_cnt <= exc_cnt + 1;
            if (exc_req && exc_round) rnd_cnt <= rnd_cnt + 1;
        end
    end
endmodule

// ==== bench/tb_sp_float_unit.sv ====
`include "sp_float_unit_consts.vh"
module tb_sp_float_unit;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         exc_req;
    wire         exc_round;
    wire         wb_en;
    wire  [31:0] wb_data;
    wire  [31:0] dest_q;
    int          wb_cnt;
    int          exc_cnt;
    int          rnd_cnt;
    int          err_total = 0;
    int          comparisons = 0;
    logic [31:0] rdat;
    logic        rerr;
    logic [31:0] last_res = 32'h0;
    always #12.5 pclk = ~pclk;
    sp_float_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .exc_req(exc_req), .exc_round(exc_round), .wb_en(wb_en),
        .wb_data(wb_data));
    pipe_model pipe_u (.pclk(pclk), .presetn(presetn), .exc_req(exc_req),
        .exc_round(exc_round), .wb_en(wb_en), .wb_data(wb_data), .dest_q(dest_q),
        .wb_cnt(wb_cnt), .exc_cnt(exc_cnt), .rnd_cnt(rnd_cnt));
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Request held until pready is sampled high; a hung slave ends the run
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            summarize();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic run_op(input logic [2:0] op, input logic [31:0] a, b, d,
        input logic [6:0] ctrl, input logic [31:0] res, input logic [10:0] st, msk,
        input logic [2:0] fl);
        int w0, x0, r0;
        apb(1'b1, `OFS_STATUS, 32'h0000_0010);
        apb(1'b1, `OFS_SRC_A, a);
        apb(1'b1, `OFS_SRC_B, b);
        apb(1'b1, `OFS_SRC_D, d);
        apb(1'b1, `OFS_CTRL, {25'h0, ctrl});
        w0 = wb_cnt; x0 = exc_cnt; r0 = rnd_cnt;
        apb(1'b1, `OFS_CMD, {29'h0, op});
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("status", {21'h0, st & msk}, rdat & {21'h0, msk});
        chk("wb exc round", {29'h0, fl}, {29'h0, wb_cnt != w0, exc_cnt != x0, rnd_cnt != r0});
        if (fl[2]) last_res = res;
        chk("destination", last_res, dest_q);
        apb(1'b0, `OFS_RESULT, 32'h0);
        chk("result reg", last_res, rdat);
    endtask
    task automatic t_bus;
        apb(1'b0, `OFS_CTRL, 32'h0); chk("ctrl reset", 32'h0, rdat);
        apb(1'b0, 8'h40, 32'h0); chk("unmapped err", 32'h1, {31'h0, rerr});
        apb(1'b1, `OFS_CTRL, 32'h0000_007f);
        apb(1'b0, `OFS_CTRL, 32'h0); chk("ctrl rw", 32'h0000_007f, rdat);
        apb(1'b1, `OFS_RESULT, 32'h1234_5678);
        apb(1'b0, `OFS_RESULT, 32'h0); chk("result ro", last_res, rdat);
        $display("test bus done");
    endtask
    task automatic t_convert;
        run_op(`OP_CTSIZ, 32'h0, 32'hc030_0000, 32'h0, 7'h00, 32'hffff_fffe,
            11'h010, 11'h01f, 3'b100);
        run_op(`OP_CTUI, 32'h0, 32'h4020_0000, 32'h0, 7'h02, 32'h0000_0003,
            11'h010, 11'h01f, 3'b100);
        run_op(`OP_CTUIZ, 32'h0, 32'h4020_0000, 32'h0, 7'h02, 32'h0000_0002,
            11'h010, 11'h01f, 3'b100);
        run_op(`OP_CTUF, 32'h0, 32'h3f00_0000, 32'h0, 7'h00, 32'h8000_0000,
            11'h000, 11'h01f, 3'b100);
        run_op(`OP_CTSIZ, 32'h0, 32'h4f80_0000, 32'h0, 7'h00, 32'h7fff_ffff,
            11'h001, 11'h1ef, 3'b100);
        run_op(`OP_CTUI, 32'h0, 32'h7fc0_0000, 32'h0, 7'h00, 32'h0,
            11'h001, 11'h1ef, 3'b100);
        run_op(`OP_CTSIZ, 32'h0, 32'h7f80_0000, 32'h0, 7'h04, 32'h0,
            11'h201, 11'h7ff, 3'b010);
        run_op(`OP_CTSIZ, 32'h0, 32'h4020_0000, 32'h0, 7'h40, 32'h0000_0002,
            11'h630, 11'h7ff, 3'b111);
        $display("test convert done");
    endtask
    task automatic t_divide;
        run_op(`OP_DIV, 32'h40c0_0000, 32'h4000_0000, 32'h0, 7'h00, 32'h4040_0000,
            11'h000, 11'h1ff, 3'b100);
        run_op(`OP_DIV, 32'h3f80_0000, 32'h7f80_0000, 32'h0, 7'h00, 32'h0,
            11'h001, 11'h1ff, 3'b100);
        run_op(`OP_DIV, 32'hbf80_0000, 32'h0, 32'h0, 7'h00, `NEG_MAX,
            11'h002, 11'h1ff, 3'b100);
        run_op(`OP_DIV, 32'hbf80_0000, 32'h0, 32'h0, 7'h08, 32'h0,
            11'h002, 11'h00f, 3'b010);
        run_op(`OP_DIV, 32'h0, 32'h0, 32'h0, 7'h00, `POS_MAX,
            11'h001, 11'h1ff, 3'b100);
        run_op(`OP_DIV, 32'h7f00_0000, 32'h3f00_0000, 32'h0, 7'h00, `POS_MAX,
            11'h014, 11'h1ff, 3'b100);
        run_op(`OP_DIV, 32'h7f00_0000, 32'h3f00_0000, 32'h0, 7'h10, 32'h0,
            11'h004, 11'h00f, 3'b010);
        $display("test divide done");
    endtask
    task automatic t_madd;
        run_op(`OP_MADD, 32'h4000_0000, 32'h4040_0000, 32'h3f80_0000, 7'h00, 32'h40e0_0000,
            11'h000, 11'h1ff, 3'b100);
        run_op(`OP_MADD, 32'h0, 32'h4040_0000, 32'h3f80_0000, 7'h00, 32'h3f80_0000,
            11'h000, 11'h1ff, 3'b100);
        run_op(`OP_MADD, 32'h7f80_0000, 32'hc000_0000, 32'h3f80_0000, 7'h00, `NEG_MAX,
            11'h001, 11'h1ef, 3'b100);
        run_op(`OP_MADD, 32'h4000_0000, 32'h4040_0000, 32'hff80_0000, 7'h00, `NEG_MAX,
            11'h000, 11'h00f, 3'b100);
        run_op(`OP_MADD, 32'h0080_0000, 32'h3f00_0000, 32'h0, 7'h00, 32'h0,
            11'h008, 11'h00f, 3'b100);
        run_op(`OP_MADD, 32'h0080_0000, 32'h3f00_0000, 32'h0, 7'h03, 32'h8000_0000,
            11'h008, 11'h00f, 3'b100);
        $display("test madd done");
    endtask
    task automatic t_max;
        run_op(`OP_MAX, 32'h3f80_0000, 32'h4000_0000, 32'h0, 7'h00, 32'h4000_0000,
            11'h000, 11'h1ff, 3'b100);
        run_op(`OP_MAX, 32'h4000_0000, 32'h3f80_0000, 32'h0, 7'h00, 32'h4000_0000,
            11'h000, 11'h1ff, 3'b100);
        run_op(`OP_MAX, 32'h7fc0_0000, 32'h3f80_0000, 32'h0, 7'h00, 32'h3f80_0000,
            11'h001, 11'h1ef, 3'b100);
        run_op(`OP_MAX, 32'h7f80_0000, 32'h3f80_0000, 32'h0, 7'h04, 32'h0,
            11'h001, 11'h00f, 3'b010);
        $display("test max done");
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_bus();
        t_convert();
        t_divide();
        t_madd();
        t_max();
        summarize();
    end
endmodule
